//--- rtl/ctm_pkg.sv
// Package for the CAN transceiver mode and wake block
package ctm_pkg;
  typedef enum logic [1:0] {
    CTM_OFF = 2'b00,
    CTM_WAKE = 2'b01,
    CTM_RXONLY = 2'b10,
    CTM_NORMAL = 2'b11
  } ctm_mode_t;
  typedef enum logic [2:0] {
    CTM_SYS_NORMAL = 3'h0,
    CTM_SYS_STOP = 3'h1,
    CTM_SYS_SLEEP = 3'h2,
    CTM_SYS_RESTART = 3'h3,
    CTM_SYS_FAILSAFE = 3'h4,
    CTM_SYS_INIT = 3'h5
  } ctm_sys_t;
  typedef struct packed {
    logic drv_en;
    logic bias_half;
  } ctm_bus_ctl_t;
  localparam int CTM_WAKE_MIN_DEF = 8;
  localparam int CTM_WAKE_MAX_DEF = 64;
  localparam int CTM_EN_SETTLE_DEF = 16;
  localparam int CTM_FIFO_DEPTH = 16;
endpackage : ctm_pkg

//--- rtl/ctm_top.sv
// Mode control, transmit gating, receive path and wake detection
`timescale 1ns/1ns
module ctm_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("Depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : ctm_fifo

module ctm_top #(
  parameter int WAKE_MIN = ctm_pkg::CTM_WAKE_MIN_DEF,
  parameter int WAKE_MAX = ctm_pkg::CTM_WAKE_MAX_DEF,
  parameter int EN_SETTLE = ctm_pkg::CTM_EN_SETTLE_DEF,
  parameter int FIFO_DEPTH = ctm_pkg::CTM_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] sys_mode,
  input wire logic [1:0] mode_wr_data,
  input wire logic mode_wr,
  input wire logic tx_data_in,
  input wire logic bus_dominant,
  output logic bus_drive_dom,
  output ctm_pkg::ctm_bus_ctl_t bus_ctl,
  output logic rx_data_out,
  output logic [1:0] mode_bits,
  output logic wake_flag,
  output logic fifo_full
);
  localparam int CW = $clog2(WAKE_MAX + EN_SETTLE + 2);
  if (WAKE_MIN < 1 || WAKE_MAX <= WAKE_MIN + 1 || EN_SETTLE < 1) begin : g_bad_counts
    $error("Bad wake or enable counts");
  end
  typedef enum logic [1:0] {
    CTM_W_IDLE = 2'b00,
    CTM_W_DOM1 = 2'b01,
    CTM_W_REC = 2'b10,
    CTM_W_DOM2 = 2'b11
  } ctm_wst_t;

  // Two-flop synchronisers for pins
  logic tx_m_r, tx_q_r, bus_m_r, bus_q_r;
  logic [2:0] sys_m_r, sys_q_r;
  always_ff @(posedge ref_clk) begin
    tx_m_r <= tx_data_in;
    tx_q_r <= tx_m_r;
    bus_m_r <= bus_dominant;
    bus_q_r <= bus_m_r;
    sys_m_r <= sys_mode;
    sys_q_r <= sys_m_r;
  end

  ctm_pkg::ctm_mode_t mode_r, mode_nxt;
  logic [2:0] sys_prev_r;
  ctm_wst_t wst_r, wst_nxt;
  logic [CW-1:0] wcnt_r, wcnt_nxt;
  logic [CW-1:0] ecnt_r;
  logic armed_r, wake_r, tx_gate_r, bus_prev_r;

  wire ctm_pkg::ctm_sys_t sysm = ctm_pkg::ctm_sys_t'(sys_q_r);
  wire sys_chg = (sys_q_r != sys_prev_r);
  wire in_norm = (sysm == ctm_pkg::CTM_SYS_NORMAL);
  wire in_stop = (sysm == ctm_pkg::CTM_SYS_STOP);
  wire in_fs = (sysm == ctm_pkg::CTM_SYS_FAILSAFE);
  wire wr_off = mode_wr && (mode_wr_data == ctm_pkg::CTM_OFF);
  wire wr_norm = mode_wr && (mode_wr_data == ctm_pkg::CTM_NORMAL) && in_norm;
  wire wr_rx = mode_wr && (mode_wr_data == ctm_pkg::CTM_RXONLY) && (in_norm || in_stop);
  wire wr_wake = mode_wr && (mode_wr_data == ctm_pkg::CTM_WAKE) && !in_fs
    && sysm != ctm_pkg::CTM_SYS_INIT;
  wire act_mode = (mode_r == ctm_pkg::CTM_NORMAL) || (mode_r == ctm_pkg::CTM_RXONLY);
  wire rearm = (sys_chg && (in_stop || in_fs))
    || ((wr_off || wr_norm || wr_rx) && mode_r == ctm_pkg::CTM_WAKE);

  // Mode selection; system forcing wins over writes
  always_comb begin
    mode_nxt = mode_r;
    if (wr_off || wr_norm || wr_rx || wr_wake) begin
      mode_nxt = ctm_pkg::ctm_mode_t'(mode_wr_data);
    end
    if (in_fs) begin
      mode_nxt = ctm_pkg::CTM_WAKE;
    end else if (act_mode && !in_norm && !in_stop) begin
      mode_nxt = ctm_pkg::CTM_WAKE;
    end
  end

  // Wake pattern: dominant, recessive, dominant, each in window
  // Phase length is count plus one at the closing edge
  wire ph_ok = (wcnt_r >= CW'(WAKE_MIN)) && (wcnt_r < CW'(WAKE_MAX - 1));
  wire edge_b = (bus_q_r != bus_prev_r);
  always_comb begin
    wst_nxt = wst_r;
    wcnt_nxt = (wcnt_r < CW'(WAKE_MAX)) ? wcnt_r + 1'b1 : wcnt_r;
    if (edge_b) begin
      wcnt_nxt = '0;
    end
    case (wst_r)
      CTM_W_IDLE: begin
        if (edge_b && bus_q_r) begin
          wst_nxt = CTM_W_DOM1;
        end
      end
      CTM_W_DOM1: begin
        if (edge_b) begin
          wst_nxt = ph_ok ? CTM_W_REC : CTM_W_IDLE;
        end
      end
      CTM_W_REC: begin
        if (edge_b) begin
          wst_nxt = ph_ok ? CTM_W_DOM2 : CTM_W_DOM1;
        end else if (!ph_ok && wcnt_r >= CW'(WAKE_MAX)) begin
          wst_nxt = CTM_W_IDLE;
        end
      end
      CTM_W_DOM2: begin
        if (edge_b || wcnt_r >= CW'(WAKE_MAX)) begin
          wst_nxt = CTM_W_IDLE;
        end
      end
      default: begin
        wst_nxt = CTM_W_IDLE;
      end
    endcase
  end
  // Wake fires once the second dominant passes the minimum, before the maximum
  wire wake_hit = (wst_r == CTM_W_DOM2) && bus_q_r && (wcnt_r == CW'(WAKE_MIN));
  // A wake seen while leaving wake mode is dropped; the sticky low needs the mode to stay
  wire wake_set = (mode_r == ctm_pkg::CTM_WAKE) && armed_r && wake_hit
    && (mode_nxt == ctm_pkg::CTM_WAKE);

  // Data path: receive samples queued so the controller sees them in order
  logic fifo_in_ready, fifo_out_valid;
  logic [0:0] fifo_out_data;
  wire rx_live = act_mode;
  ctm_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(~bus_q_r),
    .in_valid(rx_live),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= ctm_pkg::CTM_OFF;
      sys_prev_r <= ctm_pkg::CTM_SYS_INIT;
      wst_r <= CTM_W_IDLE;
      wcnt_r <= '0;
      ecnt_r <= '0;
      armed_r <= 1'b1;
      wake_r <= 1'b0;
      tx_gate_r <= 1'b0;
      bus_prev_r <= 1'b0;
      bus_drive_dom <= 1'b0;
      bus_ctl <= '0;
      rx_data_out <= 1'b1;
      mode_bits <= ctm_pkg::CTM_OFF;
      wake_flag <= 1'b0;
      fifo_full <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      sys_prev_r <= sys_q_r;
      bus_prev_r <= bus_q_r;
      wst_r <= (mode_r == ctm_pkg::CTM_WAKE && armed_r) ? wst_nxt : CTM_W_IDLE;
      wcnt_r <= wcnt_nxt;
      if (wake_set) begin
        armed_r <= 1'b0;
        wake_r <= 1'b1;
      end else begin
        if (rearm) begin
          armed_r <= 1'b1;
        end
        if (mode_nxt != ctm_pkg::CTM_WAKE) begin
          wake_r <= 1'b0;
        end
      end
      // Enable settling; early low held off until transmit input is next seen recessive
      if (mode_r != ctm_pkg::CTM_NORMAL) begin
        ecnt_r <= '0;
        tx_gate_r <= 1'b0;
      end else if (ecnt_r < CW'(EN_SETTLE)) begin
        ecnt_r <= ecnt_r + 1'b1;
      end else if (tx_q_r) begin
        tx_gate_r <= 1'b1;
      end
      bus_drive_dom <= (mode_r == ctm_pkg::CTM_NORMAL) && tx_gate_r && !tx_q_r;
      bus_ctl.drv_en <= (mode_r == ctm_pkg::CTM_NORMAL);
      bus_ctl.bias_half <= act_mode;
      if (mode_r == ctm_pkg::CTM_WAKE) begin
        rx_data_out <= !wake_r;
      end else if (rx_live && fifo_out_valid) begin
        rx_data_out <= fifo_out_data[0];
      end else begin
        rx_data_out <= 1'b1;
      end
      mode_bits <= mode_nxt;
      wake_flag <= wake_r;
      fifo_full <= !fifo_in_ready;
    end
  end

  chk_wake_low_held: assert property (@(posedge ref_clk) disable iff (rst)
    (wake_r && mode_r == ctm_pkg::CTM_WAKE) |=> !rx_data_out)
    else $error("Receive output not low after wake");
  chk_off_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == ctm_pkg::CTM_OFF) |=> !bus_drive_dom && rx_data_out)
    else $error("Off mode not quiet");
  chk_rxonly_nodrv: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == ctm_pkg::CTM_RXONLY) |=> !bus_drive_dom && !bus_ctl.drv_en)
    else $error("Driver active in receive-only");
  chk_fs_forced: assert property (@(posedge ref_clk) disable iff (rst)
    in_fs |=> mode_r == ctm_pkg::CTM_WAKE)
    else $error("Fail-safe did not force wake mode");
  chk_settle_block: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == ctm_pkg::CTM_NORMAL && ecnt_r < CW'(EN_SETTLE)) |=> !bus_drive_dom)
    else $error("Drove bus before settling");
  chk_norm_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_norm == 1'b0 && mode_r != ctm_pkg::CTM_NORMAL && !in_fs) |=> mode_r != ctm_pkg::CTM_NORMAL)
    else $error("Normal mode entered without command");
  chk_wake_bits: assert property (@(posedge ref_clk) disable iff (rst)
    (wake_r && !mode_wr && !in_fs) |=> mode_bits == 2'b01)
    else $error("Mode bits left wake-capable");
  chk_tx_follow: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == ctm_pkg::CTM_NORMAL && tx_gate_r && !tx_q_r) |=> bus_drive_dom)
    else $error("Transmit low not driven dominant");
endmodule : ctm_top

//--- testbench/ctm_ctl_model.sv
// CAN protocol controller model driving the transmit level
`timescale 1ns/1ns
module ctm_ctl_model (
  input wire logic ref_clk,
  output logic tx_data_in
);
  // Recessive while idle
  initial tx_data_in = 1'b1;
  // Level set just after an edge, held n cycles; s_early holds it low through settling
  task automatic hold(input logic lvl, input int n);
    @(posedge ref_clk);
    #1 tx_data_in = lvl;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : hold
endmodule : ctm_ctl_model

//--- testbench/can_transceiver_mode_wake_tb_top.sv
// Self-checking bench for the CAN transceiver mode and wake block
`timescale 1ns/1ns
module can_transceiver_mode_wake_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sys_mode = 3'h0;
  logic [1:0] mode_wr_data = 2'h0;
  logic mode_wr = 1'b0;
  logic ext_dom = 1'b0;
  logic tx_data_in;
  logic bus_drive_dom;
  logic rx_data_out;
  logic wake_flag;
  logic [1:0] mode_bits;
  logic fifo_full;
  ctm_pkg::ctm_bus_ctl_t bus_ctl;
  int n_errors = 0;
  int total_checks = 0;
  // Wired bus: any node driving dominant wins
  wire logic bus_dominant = bus_drive_dom | ext_dom;
  always #2 ref_clk = ~ref_clk;
  ctm_ctl_model ctl (.ref_clk(ref_clk), .tx_data_in(tx_data_in));
  ctm_top dut (.ref_clk(ref_clk), .rst(rst), .sys_mode(sys_mode),
    .mode_wr_data(mode_wr_data), .mode_wr(mode_wr), .tx_data_in(tx_data_in),
    .bus_dominant(bus_dominant), .bus_drive_dom(bus_drive_dom), .bus_ctl(bus_ctl),
    .rx_data_out(rx_data_out), .mode_bits(mode_bits), .wake_flag(wake_flag),
    .fifo_full(fifo_full));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic report(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR at %0t: output mismatch", $time);
    end
  endtask : report
  task automatic check_bit(input logic got, input logic exp);
    report(got === exp);
  endtask : check_bit
  task automatic check_mode(input logic [1:0] got, input logic [1:0] exp);
    report(got === exp);
  endtask : check_mode
  task automatic wr_mode(input logic [1:0] m);
    mode_wr_data = m;
    mode_wr = 1'b1;
    tick(1);
    mode_wr = 1'b0;
    tick(3);
  endtask : wr_mode
  task automatic set_sys(input logic [2:0] s);
    sys_mode = s;
    tick(4);
  endtask : set_sys
  // Dominant, recessive, dominant, each d cycles
  task automatic wup(input int d);
    ext_dom = 1'b1;
    tick(d);
    ext_dom = 1'b0;
    tick(d);
    ext_dom = 1'b1;
    tick(d);
    ext_dom = 1'b0;
    tick(8);
  endtask : wup
  task automatic s_reset;
    check_mode(mode_bits, 2'h0);
    check_bit(bus_ctl.drv_en, 1'b0);
    wup(20);
    check_bit(wake_flag, 1'b0);
    check_bit(rx_data_out, 1'b1);
  endtask : s_reset
  task automatic s_refuse;
    set_sys(3'h1);
    wr_mode(2'h3);
    check_mode(mode_bits, 2'h0);
    set_sys(3'h2);
    wr_mode(2'h2);
    check_mode(mode_bits, 2'h0);
    set_sys(3'h0);
  endtask : s_refuse
  task automatic s_normal;
    wr_mode(2'h3);
    check_mode(mode_bits, 2'h3);
    check_bit(bus_ctl.drv_en, 1'b1);
    check_bit(bus_ctl.bias_half, 1'b1);
    ctl.hold(1'b1, 16);
    ctl.hold(1'b0, 8);
    check_bit(bus_drive_dom, 1'b1);
    check_bit(rx_data_out, 1'b0);
    ctl.hold(1'b1, 8);
    check_bit(bus_drive_dom, 1'b0);
    check_bit(rx_data_out, 1'b1);
    set_sys(3'h1);
    check_mode(mode_bits, 2'h3);
    set_sys(3'h0);
  endtask : s_normal
  task automatic s_early;
    wr_mode(2'h0);
    check_bit(bus_ctl.bias_half, 1'b0);
    ctl.hold(1'b0, 0);
    wr_mode(2'h3);
    tick(24);
    check_bit(bus_drive_dom, 1'b0);
    ctl.hold(1'b1, 2);
    ctl.hold(1'b0, 8);
    check_bit(bus_drive_dom, 1'b1);
    ctl.hold(1'b1, 8);
  endtask : s_early
  task automatic s_rxonly;
    wr_mode(2'h2);
    check_mode(mode_bits, 2'h2);
    check_bit(bus_ctl.bias_half, 1'b1);
    ctl.hold(1'b0, 8);
    check_bit(bus_drive_dom, 1'b0);
    ext_dom = 1'b1;
    tick(8);
    check_bit(rx_data_out, 1'b0);
    ext_dom = 1'b0;
    tick(8);
    check_bit(rx_data_out, 1'b1);
    check_bit(fifo_full, 1'b0);
    ctl.hold(1'b1, 1);
  endtask : s_rxonly
  task automatic s_wake;
    set_sys(3'h2);
    wr_mode(2'h1);
    check_mode(mode_bits, 2'h1);
    wup(4);
    tick(70);
    wup(70);
    tick(70);
    check_bit(wake_flag, 1'b0);
    wup(20);
    check_bit(wake_flag, 1'b1);
    tick(20);
    check_bit(rx_data_out, 1'b0);
    check_mode(mode_bits, 2'h1);
    wr_mode(2'h0);
    tick(8);
    check_bit(rx_data_out, 1'b1);
    wr_mode(2'h1);
    wup(20);
    check_bit(wake_flag, 1'b1);
    wr_mode(2'h0);
    set_sys(3'h4);
    tick(4);
    check_mode(mode_bits, 2'h1);
    wup(20);
    check_bit(wake_flag, 1'b1);
    set_sys(3'h0);
    wr_mode(2'h3);
    check_mode(mode_bits, 2'h3);
    check_bit(rx_data_out, 1'b1);
  endtask : s_wake
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    tick(3);
    rst = 1'b0;
    tick(3);
    s_reset();
    s_refuse();
    s_normal();
    s_early();
    s_rxonly();
    s_wake();
    complete_run();
  end
endmodule : can_transceiver_mode_wake_tb_top
